// *** icm_params.svh ***
// Constants shared by both ends of the channel mux control link
`ifndef ICM_PARAMS_SVH
`define ICM_PARAMS_SVH
`define ICM_CLK_NS 4
`define ICM_SCL_NS 160
`define ICM_QTRS 4
`define ICM_QTR_CYC ((`ICM_SCL_NS) / (`ICM_QTRS * `ICM_CLK_NS))
`define ICM_ADDR_HI 4'h7
`define ICM_CTRL_RST 8'h00
`define ICM_BYTE_BITS 4'h8
`define ICM_EN_BIT 2
`define ICM_SPARE_BIT 3
`define ICM_IRQ_LSB 4
`define ICM_IRQ_MSB 7
`define ICM_IDX_HI 1
`define ICM_IDX_LO 0
`endif

// *** icm_pkg.sv ***
// Types shared by the channel mux ends
package icm_pkg;
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_WDATA, DS_WACK, DS_RDATA, DS_RACK
  } icm_dev_st_t;
  typedef enum logic [1:0] {
    MS_IDLE, MS_START, MS_BIT, MS_STOP
  } icm_mst_st_t;
endpackage : icm_pkg

// *** icm_bus_if.sv ***
// Upstream two-wire link between bus master and channel mux
`timescale 1ns/10ps
interface icm_bus_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // Open drain with pull-ups: any enable pulls the line low
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_d_oe);
  modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
  modport device (output sda_d_oe, input scl, input sda);
endinterface : icm_bus_if

// *** icm_sync.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module icm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : icm_sync

// *** icm_mux_dev.sv ***
// Channel mux device end: slave state machine, control register, irq
//
// Behaviour
// [R01] Bit 2 enables; bits 1:0 pick channel
// [R02] At most one channel connected at once
// [R03] Control register resets to all zeros
// [R04] Any irq input low pulls irq output
// [R05] Irq detection independent of selected channel
// [R06] Bits 7:4 report channels 0..3 irq
// [R07] Read captures current irq levels
// [R08] Bit set when input asserted, any combination
// [R09] Irq indication not latched
// [R10] Master queries every device on flagged channel; the bench only selects that channel
// [R11] Irq inputs readable as general inputs
// [R12] Bus state machine resets to idle
// [R13] Data stable while clock high
// [R14] Start and stop detected while clock high
// [R15] Master starts only on idle bus
// [R16] Each byte followed by acknowledge bit
// [R17] Device acknowledges each received byte low
// [R18] Sender releases data before acknowledge slot
// [R19] Master nack ends read; device releases
// [R20] Address lsb: 1 read, 0 write
// [R21] Last written byte is kept
// [R22] New selection applies after stop
// [R23] Low address bits match address straps
// [R24] Read gives selection and irq bits
`timescale 1ns/10ps
`include "icm_params.svh"
module icm_mux_dev
  import icm_pkg::*;
#(
  parameter logic [3:0] ADDR_HI = `ICM_ADDR_HI
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Upstream link
  icm_bus_if.device bus,
  // Address straps
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2,
  // Channel interrupt inputs
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  input wire logic chan2_irq_in_n,
  input wire logic chan3_irq_in_n,
  // Open-drain interrupt output
  output logic irq_out,
  output logic irq_out_oe,
  // Downstream pass-gate enables, one per channel, and the registered status byte port
  output logic [3:0] chan_connect,
  output logic [7:0] channel_control
);
  icm_dev_st_t st_r;
  logic [1:0] line_s;
  logic scl_s, sda_s, scl_p, sda_p;
  logic [2:0] strap_s;
  logic [3:0] irq_s;
  logic start_ev, stop_ev, rise_ev, fall_ev;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic rd_r, ack_r;
  logic [3:0] ctrl_r, pend_r;
  logic pend_vld_r;
  logic sda_oe_r;
  logic [3:0] conn_r;
  logic irq_oe_r;
  logic [7:0] view_r;

  // One-hot decode of a selection nibble; all zero when disabled
  function automatic logic [3:0] chan_decode(input logic [3:0] c);
    logic [3:0] oh;
    oh = '0;
    if (c[`ICM_EN_BIT]) begin
      oh[{c[`ICM_IDX_HI], c[`ICM_IDX_LO]}] = 1'b1;
    end
    return oh;
  endfunction : chan_decode

  // Status byte: irq flags high, stored selection low
  function automatic logic [7:0] status_byte(input logic [3:0] irq_n,
                                             input logic [3:0] c);
    return {~irq_n, c};
  endfunction : status_byte

  icm_sync #(.W(2), .RST(2'b11)) u_line_sync (
    .clk(clk),
    .rstn(rstn),
    .d({bus.scl, bus.sda}),
    .q(line_s)
  );

  icm_sync #(.W(3), .RST(3'b000)) u_strap_sync (
    .clk(clk),
    .rstn(rstn),
    .d({addr_strap_2, addr_strap_1, addr_strap_0}),
    .q(strap_s)
  );

  icm_sync #(.W(4), .RST(4'hF)) u_irq_sync (
    .clk(clk),
    .rstn(rstn),
    .d({chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n}),
    .q(irq_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  // Data edges with clock high are conditions, not bits
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s; // [R14] [R13]
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s; // [R14]
  assign rise_ev = scl_s & ~scl_p;
  assign fall_ev = ~scl_s & scl_p;

  // Slave state machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= DS_IDLE; // [R12]
      cnt_r <= '0;
      sh_r <= '0;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_ev) begin
      st_r <= DS_IDLE;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      st_r <= DS_ADDR; // repeated start allowed too
      cnt_r <= '0;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        DS_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        DS_ADDR, DS_WDATA: begin
          if (rise_ev) begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (fall_ev && cnt_r == `ICM_BYTE_BITS) begin
            cnt_r <= '0;
            if (st_r == DS_WDATA) begin
              st_r <= DS_WACK;
              sda_oe_r <= 1'b1; // [R16] [R17]
            end else if (sh_r[7:1] == {ADDR_HI, strap_s}) begin // [R23]
              st_r <= DS_ADDR_ACK;
              rd_r <= sh_r[0]; // [R20]
              sda_oe_r <= 1'b1; // [R17]
            end else begin
              st_r <= DS_IDLE; // Not ours: wait for next start
            end
          end
        end
        DS_ADDR_ACK, DS_WACK: begin
          if (fall_ev) begin
            if (st_r == DS_ADDR_ACK && rd_r) begin
              // Inputs sampled once per byte, at the read
              sh_r <= status_byte(irq_s, ctrl_r); // [R07] [R24] [R11]
              sda_oe_r <= irq_s[3]; // bit 7 is channel 3 flag
              st_r <= DS_RDATA;
            end else begin
              sda_oe_r <= 1'b0;
              st_r <= DS_WDATA;
            end
          end
        end
        DS_RDATA: begin
          if (rise_ev) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (fall_ev) begin
            if (cnt_r == `ICM_BYTE_BITS) begin
              cnt_r <= '0;
              sda_oe_r <= 1'b0; // [R18]
              st_r <= DS_RACK;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
            end
          end
        end
        DS_RACK: begin
          if (rise_ev) begin
            ack_r <= ~sda_s;
          end else if (fall_ev) begin
            if (ack_r) begin
              sh_r <= status_byte(irq_s, ctrl_r); // [R07]
              sda_oe_r <= irq_s[3];
              st_r <= DS_RDATA;
            end else begin
              sda_oe_r <= 1'b0; // [R19]
              st_r <= DS_IDLE;
            end
          end
        end
        default: begin
          st_r <= DS_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Pending byte: later bytes overwrite earlier ones
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= '0;
      pend_vld_r <= 1'b0;
    end else if (stop_ev) begin
      pend_vld_r <= 1'b0;
    end else if (st_r == DS_WDATA && fall_ev && cnt_r == `ICM_BYTE_BITS) begin
      pend_r <= sh_r[3:0]; // [R21]
      pend_vld_r <= 1'b1;
    end
  end

  // Commit on stop so downstream lines are idle when switched
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= 4'(`ICM_CTRL_RST); // [R03]
    end else if (stop_ev && pend_vld_r) begin
      ctrl_r <= pend_r; // [R22]
    end
  end

  // Pass-gate enables decoded from committed selection only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conn_r <= '0; // [R03]
    end else begin
      conn_r <= chan_decode(ctrl_r); // [R01] [R02]
    end
  end

  // Live AND of the inputs; no latching so it drops with the sources
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= ~&irq_s; // [R04] [R05] [R09]
    end
  end

  assign bus.sda_d_oe = sda_oe_r;
  assign chan_connect = conn_r;
  // Registered view keeps the status port free of decode glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      view_r <= `ICM_CTRL_RST;
    end else begin
      view_r <= status_byte(irq_s, ctrl_r); // [R06] [R08]
    end
  end

  assign irq_out = 1'b0;
  assign irq_out_oe = irq_oe_r;
  assign channel_control = view_r;
endmodule : icm_mux_dev

// *** icm_mux_mst.sv ***
// Upstream bus master end: one address byte plus one data byte
`timescale 1ns/10ps
`include "icm_params.svh"
module icm_mux_mst
  import icm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Upstream link
  icm_bus_if.master bus,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // Response
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [7:0] rsp_data
);
  localparam logic [7:0] QTR = 8'(`ICM_QTR_CYC);
  icm_mst_st_t st_r;
  logic [1:0] line_s;
  logic [7:0] div_r;
  logic tick;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic byte_r, rd_r, nack_r;
  logic [7:0] sh_r, data_r;
  logic scl_oe_r, sda_oe_r;
  logic rsp_vld_r;
  logic [7:0] rsp_data_r;
  logic rsp_nack_r;

  icm_sync #(.W(2), .RST(2'b11)) u_line_sync (
    .clk(clk),
    .rstn(rstn),
    .d({bus.scl, bus.sda}),
    .q(line_s)
  );

  // Quarter-period enable for the serial clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= '0;
    end else if (div_r == QTR - 8'h01) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  assign tick = (div_r == QTR - 8'h01);

  assign cmd_ready = (st_r == MS_IDLE) & (&line_s); // [R15]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= MS_IDLE;
      q_r <= '0;
      bit_r <= '0;
      byte_r <= 1'b0;
      rd_r <= 1'b0;
      nack_r <= 1'b0;
      sh_r <= '0;
      data_r <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rsp_vld_r <= 1'b0;
      rsp_data_r <= '0;
      rsp_nack_r <= 1'b0;
    end else begin
      rsp_vld_r <= 1'b0;
      case (st_r)
        MS_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            sh_r <= {`ICM_ADDR_HI, cmd_addr, cmd_read};
            data_r <= cmd_read ? 8'hFF : cmd_data;
            rd_r <= cmd_read;
            byte_r <= 1'b0;
            bit_r <= '0;
            nack_r <= 1'b0;
            q_r <= '0;
            st_r <= MS_START;
          end
        end
        MS_START: begin
          if (tick) begin
            sda_oe_r <= 1'b1; // [R14]
            st_r <= MS_BIT;
          end
        end
        MS_BIT: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: begin
                scl_oe_r <= 1'b1;
                // Data only moves while clock is low
                if (bit_r == `ICM_BYTE_BITS) begin
                  sda_oe_r <= 1'b0; // [R18] [R19]
                end else begin
                  sda_oe_r <= ~sh_r[7]; // [R13]
                end
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (bit_r == `ICM_BYTE_BITS) begin
                  if (!byte_r) begin
                    nack_r <= line_s[0]; // [R16]
                  end
                end else begin
                  sh_r <= {sh_r[6:0], line_s[0]};
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                if (bit_r == `ICM_BYTE_BITS) begin
                  bit_r <= '0;
                  if (!byte_r && !nack_r) begin
                    byte_r <= 1'b1;
                    sh_r <= data_r;
                  end else begin
                    rsp_data_r <= sh_r;
                    st_r <= MS_STOP;
                  end
                end else begin
                  bit_r <= bit_r + 4'h1;
                end
              end
            endcase
          end
        end
        MS_STOP: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                sda_oe_r <= 1'b0; // [R14]
                rsp_vld_r <= 1'b1;
                rsp_nack_r <= nack_r;
                st_r <= MS_IDLE;
              end
              default: st_r <= MS_IDLE;
            endcase
          end
        end
        default: st_r <= MS_IDLE;
      endcase
    end
  end

  assign bus.scl_m_oe = scl_oe_r;
  assign bus.sda_m_oe = sda_oe_r;
  assign rsp_valid = rsp_vld_r;
  assign rsp_nack = rsp_nack_r;
  assign rsp_data = rsp_data_r;
endmodule : icm_mux_mst

// *** icm_mux_chk.sv ***
// Assertions on the upstream two-wire link
`timescale 1ns/10ps
`include "icm_params.svh"
module icm_mux_chk #(
  parameter logic [3:0] ADDR_HI = `ICM_ADDR_HI,
  parameter logic [2:0] STRAPS = 3'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic rd_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Rises since start; the stop's own rise leaves 1 behind
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_r <= 4'h0;
      byte_r <= 2'h0;
    end else if (scl && $fell(sda)) begin
      bit_r <= 4'h0;
      byte_r <= 2'h0;
    end else if ($rose(scl)) begin
      bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
      if (bit_r == 4'h8 && byte_r != 2'h3) begin
        byte_r <= byte_r + 2'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 8'h00;
      rd_r <= 1'b0;
    end else if ($rose(scl)) begin
      sh_r <= {sh_r[6:0], sda};
      if (bit_r == 4'h8 && byte_r == 2'h0) begin
        rd_r <= sh_r[0];
      end
    end
  end
  sequence s_ack_rise;
    $rose(scl) && bit_r == 4'h8;
  endsequence
  sequence s_stop;
    scl && $past(scl) && $fell(sda_m_oe);
  endsequence
  a_dev_edge_low:
    assert property (!$stable(sda_d_oe) |-> !scl)
    else $error("device moved data while clock high");
  a_ack_held:
    assert property ($rose(scl) && sda_d_oe |-> sda_d_oe throughout scl [*8])
    else $error("device let go during clock high");
  a_dev_pull_slot:
    assert property ($rose(scl) && sda_d_oe |->
      bit_r == 4'h8 || (byte_r != 2'h0 && rd_r))
    else $error("device pulled data outside its slots");
  a_addr_match:
    assert property (s_ack_rise |-> byte_r != 2'h0 ||
      sda_d_oe == (sh_r[7:1] == {ADDR_HI, STRAPS}))
    else $error("address ack does not follow address match");
  a_write_ack:
    assert property (s_ack_rise |-> byte_r == 2'h0 || rd_r || sda_d_oe)
    else $error("written byte not acknowledged");
  a_read_nack_free:
    assert property (s_ack_rise |-> byte_r == 2'h0 || !rd_r || !sda_d_oe)
    else $error("device holds data in master ack slot");
  a_master_frees:
    assert property (s_ack_rise |-> !sda_m_oe)
    else $error("master holds data in ack slot");
  a_start_idle:
    assert property (!scl_m_oe && $rose(sda_m_oe) |-> $past(sda) && $past(scl))
    else $error("start on a busy link");
  a_stop_after_byte:
    assert property (s_stop |-> bit_r == 4'h1 && byte_r != 2'h0)
    else $error("stop not right after an ack slot");
endmodule : icm_mux_chk

// *** tb_i2c_mux_channel_select_irq.sv ***
// Bench joining master and mux device over the two-wire link
`timescale 1ns/10ps
`include "icm_params.svh"
module tb_i2c_mux_channel_select_irq;
  localparam logic [2:0] STRAPS = 3'h5;
  localparam logic [7:0] SEL [5] = '{8'h04, 8'h0D, 8'hA6, 8'h07, 8'h0B};
  localparam logic [3:0] PAT [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'h0};
  logic clk, rstn, cmd_valid, cmd_read, cmd_ready, rsp_valid, rsp_nack;
  logic irq_out, irq_out_oe, got_nack;
  logic [2:0] cmd_addr;
  logic [3:0] irq_n, chan_connect, exp_conn;
  logic [7:0] cmd_data, rsp_data, channel_control, got_data;
  int n_errors;
  int tests_run;

  icm_bus_if bus_if ();
  icm_mux_dev icm_mux_dev_inst (.clk(clk), .rstn(rstn), .bus(bus_if),
    .addr_strap_0(STRAPS[0]), .addr_strap_1(STRAPS[1]),
    .addr_strap_2(STRAPS[2]), .chan0_irq_in_n(irq_n[0]),
    .chan1_irq_in_n(irq_n[1]), .chan2_irq_in_n(irq_n[2]),
    .chan3_irq_in_n(irq_n[3]), .irq_out(irq_out),
    .irq_out_oe(irq_out_oe), .chan_connect(chan_connect),
    .channel_control(channel_control));
  icm_mux_mst icm_mux_mst_inst (.clk(clk), .rstn(rstn), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .rsp_data(rsp_data));
  icm_mux_chk #(.STRAPS(STRAPS)) icm_mux_chk_inst (.clk(clk), .rstn(rstn),
    .scl_m_oe(bus_if.scl_m_oe), .sda_m_oe(bus_if.sda_m_oe),
    .sda_d_oe(bus_if.sda_d_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // One command, then wait for its response pulse
  task automatic xfer(input logic rd, input logic [2:0] adr,
                      input logic [7:0] dat);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
      if (i > 200) begin
        n_errors++;
        close_out();
      end
    end while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= adr;
    cmd_data <= dat;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      // Data byte is taken by now but its stop has not come yet
      if (i == 720) check({4'h0, chan_connect}, {4'h0, exp_conn});
      if (rsp_valid === 1'b1) break;
    end
    if (i >= 3000) begin
      n_errors++;
      close_out();
    end
    got_data = rsp_data;
    got_nack = rsp_nack;
  endtask : xfer

  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 3'h0;
    cmd_data = 8'h00;
    irq_n = 4'hF;
    exp_conn = 4'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({4'h0, chan_connect}, 8'h00);
    check(channel_control, 8'h00);
    // Every channel, disabled index, spare bit and read-only upper bits
    for (int k = 0; k < 5; k++) begin
      xfer(1'b0, STRAPS, SEL[k]);
      check({7'h0, got_nack}, 8'h00);
      exp_conn = SEL[k][2] ? (4'h1 << SEL[k][1:0]) : 4'h0;
      repeat (10) @(negedge clk);
      check({4'h0, chan_connect}, {4'h0, exp_conn});
      check({7'h0, $onehot0(chan_connect)}, 8'h01);
      xfer(1'b1, STRAPS, 8'h00);
      check(got_data, {4'h0, SEL[k][3:0]});
    end
    xfer(1'b0, STRAPS ^ 3'h1, 8'h05);
    check({7'h0, got_nack}, 8'h01);
    repeat (10) @(negedge clk);
    check({4'h0, chan_connect}, {4'h0, exp_conn});
    xfer(1'b0, STRAPS, 8'h06);
    exp_conn = 4'h4;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      irq_n <= ~PAT[k];
      repeat (6) @(negedge clk);
      check({7'h0, irq_out_oe}, {7'h0, |PAT[k]});
      check({7'h0, irq_out}, 8'h00);
      check(channel_control, {PAT[k], 4'h6});
      xfer(1'b1, STRAPS, 8'h00);
      check(got_data, {PAT[k], 4'h6});
    end
    // Flag on channel 1 only: select that channel to find the source
    @(posedge clk);
    irq_n <= 4'hD;
    repeat (6) @(negedge clk);
    xfer(1'b1, STRAPS, 8'h00);
    check(got_data, 8'h26);
    xfer(1'b0, STRAPS, 8'h05);
    exp_conn = 4'h2;
    repeat (10) @(negedge clk);
    check({4'h0, chan_connect}, {4'h0, exp_conn});
    close_out();
  end
endmodule : tb_i2c_mux_channel_select_irq
